/* rtl/eisvs_pkg.sv */
/*
 * eisvs_pkg: constants, register map and carrier types of the external
 * interrupt sense and vector select block.
 * assumes: 8-bit register port with one-cycle strobes.
 */
package eisvs_pkg;
  localparam logic [7:0] ADDR_MCU_CONTROL = 8'h35;
  localparam logic [7:0] ADDR_SENSE_LOW = 8'h69;
  localparam logic [7:0] ADDR_SENSE_HIGH = 8'h6a;
  localparam logic [7:0] ADDR_EXT_MASK = 8'h3d;
  localparam logic [7:0] ADDR_EXT_FLAG = 8'h3c;
  localparam logic [7:0] ADDR_PC_CTRL = 8'h68;
  localparam logic [7:0] ADDR_PC_FLAG = 8'h3b;
  localparam logic [7:0] ADDR_PC_MASK0 = 8'h6b;
  localparam logic [7:0] ADDR_PC_MASK1 = 8'h6c;
  localparam logic [7:0] ADDR_PC_MASK2 = 8'h6d;

  localparam int MCU_UNLOCK_BIT = 0;
  localparam int MCU_SELECT_BIT = 1;
  localparam logic [7:0] MCU_PLAIN_MASK = 8'h90;
  localparam logic [7:0] REG_RESET = 8'h00;

  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;

  localparam int NUM_EXT = 8;
  localparam int NUM_PC = 24;
  localparam int NUM_GROUPS = 3;
  localparam logic [3:0] VEC_PC0 = 4'h8;
  localparam logic [3:0] VEC_NONE = 4'hf;

  typedef enum logic [1:0] {
    SENSE_LOW,
    SENSE_ANY,
    SENSE_FALL,
    SENSE_RISE
  } eisvs_sense_t;

  typedef enum logic [1:0] {
    VC_IDLE,
    VC_UNLOCKED,
    VC_HOLD
  } eisvs_vc_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } eisvs_bus_t;

  typedef struct packed {
    logic valid;
    logic [3:0] vector;
  } eisvs_irq_t;
endpackage

/* rtl/eisvs_top.sv */
/*
 * eisvs_top: external interrupt sensing on eight request pins, pin-change
 * detection on 24 inputs in three groups, vector priority, and the protected
 * vector table relocation sequence.
 * assumes: pins already synchronous to clk; cpu gives i-flag, execution
 * region, lock bits, retire and acknowledge pulses.
 */
// Functional notes
// - select zero: vectors at flash start, else boot
// - block interrupts during unlock and following instruction
// - unlock clears after four cycles or select write
// - lock bits block interrupts from other region
// - output-driven pins still raise interrupts
// - group request when enabled pin of group toggles
// - pin changes also raise combinational wake request
// - low level and low-pin edges raise wake
// - level mode requests while pin held low
// - level vanished before start-up gives no interrupt
// - request needs i-flag and per-pin mask bit
// - low pins: low, any edge, fall, rise
// - high pins: low, change, fall, rise
// - high pins sampled each clock before edges
// - low sense register packs pin3 field highest
// - flag sets on event, clears on vector/write-one
// - mask register has eight enables, reset zero
`timescale 1ns/10ps
module eisvs_top (
  // clock, enable, reset
  input wire logic clk,
  input wire logic clkEn,
  input wire logic reset_n,
  // register port
  input wire eisvs_pkg::eisvs_bus_t regBus,
  output logic [7:0] regRdata,
  // pins
  input wire logic [7:0] extIrqPins,
  input wire logic [23:0] pinChangeInputs,
  // cpu side
  input wire logic globalIrqEnable,
  input wire logic execInBoot,
  input wire logic applicationLockBit,
  input wire logic bootLockBit,
  input wire logic [16:0] bootSectionStart,
  input wire logic instrRetire,
  input wire logic irqAck,
  output eisvs_pkg::eisvs_irq_t irqOut,
  output logic [16:0] vectorBase,
  output logic vectorTableSelect,
  output logic wakeRequest
);
  import eisvs_pkg::*;

  // edge test shared by all eight request pins; low-level mode gives no hit
  function automatic logic senseHit(input logic [1:0] mode, input logic cur, input logic prev);
    logic hit;
    hit = 1'b0;
    case (eisvs_sense_t'(mode))
      SENSE_ANY: hit = cur ^ prev;
      SENSE_FALL: hit = prev & ~cur;
      SENSE_RISE: hit = cur & ~prev;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [1:0] senseOf(input logic [15:0] fields, input int pin);
    return fields[2*pin +: 2];
  endfunction

  logic [7:0] mcuPlain_ff, nxt_mcuPlain;
  logic vectorSel_ff, nxt_vectorSel;
  logic unlock_ff, nxt_unlock;
  logic [2:0] unlockCnt_ff, nxt_unlockCnt;
  eisvs_vc_state_t vcState_ff, nxt_vcState;
  logic [7:0] senseLow_ff, nxt_senseLow;
  logic [7:0] senseHigh_ff, nxt_senseHigh;
  logic [7:0] extMask_ff, nxt_extMask;
  logic [7:0] extFlag_ff, nxt_extFlag;
  logic [2:0] pcEnable_ff, nxt_pcEnable;
  logic [2:0] pcFlag_ff, nxt_pcFlag;
  logic [23:0] pcMask_ff, nxt_pcMask;
  logic [7:0] extPrev_ff, nxt_extPrev;
  logic [23:0] pcPrev_ff, nxt_pcPrev;
  logic [7:0] rdata_ff, nxt_rdata;
  eisvs_irq_t irq_ff, nxt_irq;
  logic [16:0] vecBase_ff, nxt_vecBase;

  logic wrMcu;
  logic seqBlock;
  logic lockBlock;
  logic [15:0] senseAll;
  logic [7:0] extEvent;
  logic [7:0] levelMode;
  logic [7:0] extPending;
  logic [2:0] pcEvent;
  logic [10:0] pending;

  assign senseAll = {senseHigh_ff, senseLow_ff};
  assign wrMcu = regBus.wr && (regBus.addr == ADDR_MCU_CONTROL);

  // vector change sequence
  always_comb begin
    nxt_vectorSel = vectorSel_ff;
    nxt_unlock = unlock_ff;
    nxt_unlockCnt = unlockCnt_ff;
    nxt_vcState = vcState_ff;
    nxt_mcuPlain = mcuPlain_ff;
    if (wrMcu) begin
      nxt_mcuPlain = regBus.wdata & MCU_PLAIN_MASK;
    end
    case (vcState_ff)
      VC_IDLE: begin
        if (wrMcu && regBus.wdata[MCU_UNLOCK_BIT]) begin
          nxt_unlock = 1'b1;
          nxt_unlockCnt = UNLOCK_CYCLES;
          nxt_vcState = VC_UNLOCKED;
        end
      end
      VC_UNLOCKED: begin
        if (wrMcu && !regBus.wdata[MCU_UNLOCK_BIT]) begin
          // select accepted only inside the unlock window
          nxt_vectorSel = regBus.wdata[MCU_SELECT_BIT];
          nxt_unlock = 1'b0;
          nxt_unlockCnt = 3'h0;
          nxt_vcState = VC_HOLD;
        end else if (unlockCnt_ff == 3'h1) begin
          nxt_unlock = 1'b0;
          nxt_unlockCnt = 3'h0;
          nxt_vcState = VC_IDLE;
        end else begin
          nxt_unlockCnt = unlockCnt_ff - 3'h1;
        end
      end
      VC_HOLD: begin
        // wait until the instruction after the select write retires
        if (instrRetire) begin
          nxt_vcState = VC_IDLE;
        end
      end
      default: nxt_vcState = VC_IDLE;
    endcase
  end

  // blocking starts in the very cycle the unlock write lands
  assign seqBlock = (vcState_ff != VC_IDLE) ||
    (wrMcu && regBus.wdata[MCU_UNLOCK_BIT]);
  assign lockBlock = (vectorSel_ff && applicationLockBit && !execInBoot) ||
    (!vectorSel_ff && bootLockBit && execInBoot);

  // pin sensing; no direction input exists, so driven pins count too
  always_comb begin
    extEvent = 8'h00;
    levelMode = 8'h00;
    pcEvent = 3'h0;
    for (int i = 0; i < NUM_EXT; i++) begin
      // pins 7:4 compare two clock samples
      extEvent[i] = senseHit(senseOf(senseAll, i), extIrqPins[i], extPrev_ff[i]);
      levelMode[i] = (senseOf(senseAll, i) == 2'(SENSE_LOW));
    end
    for (int g = 0; g < NUM_GROUPS; g++) begin
      pcEvent[g] = |((pinChangeInputs[8*g +: 8] ^ pcPrev_ff[8*g +: 8]) &
        pcMask_ff[8*g +: 8]);
    end
  end

  // level requests are live, never latched: a level gone before the
  // cpu is up again leaves nothing behind
  assign extPending = (extFlag_ff & ~levelMode) |
    (levelMode & ~extIrqPins);

  // no clock needed for this path, so it can wake a halted core
  // only groups whose enable bit is set may wake the core
  assign wakeRequest = |(pcEvent & pcEnable_ff) || |(extMask_ff[3:0] &
    (extEvent[3:0] | (levelMode[3:0] & ~extIrqPins[3:0]))) ||
    |(extMask_ff[7:4] & levelMode[7:4] & ~extIrqPins[7:4]);

  assign pending = {pcFlag_ff & pcEnable_ff, extPending & extMask_ff};

  // register writes, flags, priority
  always_comb begin
    nxt_senseLow = senseLow_ff;
    nxt_senseHigh = senseHigh_ff;
    nxt_extMask = extMask_ff;
    nxt_pcEnable = pcEnable_ff;
    nxt_pcMask = pcMask_ff;
    nxt_extFlag = extFlag_ff;
    nxt_pcFlag = pcFlag_ff;
    nxt_extPrev = extIrqPins;
    nxt_pcPrev = pinChangeInputs;
    nxt_irq = '{valid: 1'b0, vector: VEC_NONE};
    nxt_rdata = 8'h00;
    nxt_vecBase = nxt_vectorSel ? bootSectionStart : 17'h00000;
    if (regBus.wr) begin
      if (regBus.addr == ADDR_SENSE_LOW) begin
        nxt_senseLow = regBus.wdata;
      end else if (regBus.addr == ADDR_SENSE_HIGH) begin
        nxt_senseHigh = regBus.wdata;
      end else if (regBus.addr == ADDR_EXT_MASK) begin
        nxt_extMask = regBus.wdata;
      end else if (regBus.addr == ADDR_EXT_FLAG) begin
        nxt_extFlag = extFlag_ff & ~regBus.wdata;
      end else if (regBus.addr == ADDR_PC_CTRL) begin
        nxt_pcEnable = regBus.wdata[2:0];
      end else if (regBus.addr == ADDR_PC_FLAG) begin
        nxt_pcFlag = pcFlag_ff & ~regBus.wdata[2:0];
      end else if (regBus.addr == ADDR_PC_MASK0) begin
        nxt_pcMask[7:0] = regBus.wdata;
      end else if (regBus.addr == ADDR_PC_MASK1) begin
        nxt_pcMask[15:8] = regBus.wdata;
      end else if (regBus.addr == ADDR_PC_MASK2) begin
        nxt_pcMask[23:16] = regBus.wdata;
      end
    end
    // vectoring clears the flag of the acknowledged source
    if (irqAck && irq_ff.valid) begin
      if (irq_ff.vector < VEC_PC0) begin
        nxt_extFlag[irq_ff.vector[2:0]] = 1'b0;
      end else begin
        nxt_pcFlag[2'(irq_ff.vector - VEC_PC0)] = 1'b0;
      end
    end
    // set after clear so a coinciding event is kept
    nxt_extFlag = (nxt_extFlag | extEvent) & ~levelMode;
    nxt_pcFlag = nxt_pcFlag | pcEvent;
    if (globalIrqEnable && !seqBlock && !lockBlock) begin
      for (int v = 10; v >= 0; v--) begin
        if (pending[v]) begin
          nxt_irq = '{valid: 1'b1, vector: 4'(v)};
        end
      end
    end
    // ack pulls the request down one cycle so it is not taken twice
    if (irqAck) begin
      nxt_irq = '{valid: 1'b0, vector: VEC_NONE};
    end
    if (regBus.rd) begin
      if (regBus.addr == ADDR_MCU_CONTROL) begin
        nxt_rdata = mcuPlain_ff | {6'h00, vectorSel_ff, unlock_ff};
      end else if (regBus.addr == ADDR_SENSE_LOW) begin
        nxt_rdata = senseLow_ff;
      end else if (regBus.addr == ADDR_SENSE_HIGH) begin
        nxt_rdata = senseHigh_ff;
      end else if (regBus.addr == ADDR_EXT_MASK) begin
        nxt_rdata = extMask_ff;
      end else if (regBus.addr == ADDR_EXT_FLAG) begin
        nxt_rdata = extFlag_ff;
      end else if (regBus.addr == ADDR_PC_CTRL) begin
        nxt_rdata = {5'h00, pcEnable_ff};
      end else if (regBus.addr == ADDR_PC_FLAG) begin
        nxt_rdata = {5'h00, pcFlag_ff};
      end else if (regBus.addr == ADDR_PC_MASK0) begin
        nxt_rdata = pcMask_ff[7:0];
      end else if (regBus.addr == ADDR_PC_MASK1) begin
        nxt_rdata = pcMask_ff[15:8];
      end else if (regBus.addr == ADDR_PC_MASK2) begin
        nxt_rdata = pcMask_ff[23:16];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mcuPlain_ff <= REG_RESET;
      vectorSel_ff <= 1'b0;
      unlock_ff <= 1'b0;
      unlockCnt_ff <= 3'h0;
      vcState_ff <= VC_IDLE;
      senseLow_ff <= REG_RESET;
      senseHigh_ff <= REG_RESET;
      extMask_ff <= REG_RESET;
      extFlag_ff <= REG_RESET;
      pcEnable_ff <= 3'h0;
      pcFlag_ff <= 3'h0;
      pcMask_ff <= 24'h000000;
      extPrev_ff <= 8'hff;
      pcPrev_ff <= 24'h000000;
      rdata_ff <= 8'h00;
      irq_ff <= '{valid: 1'b0, vector: VEC_NONE};
      vecBase_ff <= 17'h00000;
    end else if (clkEn) begin
      mcuPlain_ff <= nxt_mcuPlain;
      vectorSel_ff <= nxt_vectorSel;
      unlock_ff <= nxt_unlock;
      unlockCnt_ff <= nxt_unlockCnt;
      vcState_ff <= nxt_vcState;
      senseLow_ff <= nxt_senseLow;
      senseHigh_ff <= nxt_senseHigh;
      extMask_ff <= nxt_extMask;
      extFlag_ff <= nxt_extFlag;
      pcEnable_ff <= nxt_pcEnable;
      pcFlag_ff <= nxt_pcFlag;
      pcMask_ff <= nxt_pcMask;
      extPrev_ff <= nxt_extPrev;
      pcPrev_ff <= nxt_pcPrev;
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
      vecBase_ff <= nxt_vecBase;
    end
  end

  assign regRdata = rdata_ff;
  assign irqOut = irq_ff;
  assign vectorBase = vecBase_ff;
  assign vectorTableSelect = vectorSel_ff;
endmodule

/* test/eisvs_top_properties.sv */
/* eisvs_top_properties: port-level assertions for eisvs_top.
   assumes: bound onto eisvs_top; one clock, synchronous active-low reset. */
`timescale 1ns/10ps
module eisvs_top_properties (
  // clock, reset
  input wire logic clk,
  input wire logic clkEn,
  input wire logic reset_n,
  // register port
  input wire eisvs_pkg::eisvs_bus_t regBus,
  input wire logic [7:0] regRdata,
  // pins
  input wire logic [7:0] extIrqPins,
  input wire logic [23:0] pinChangeInputs,
  // cpu side
  input wire logic globalIrqEnable,
  input wire logic execInBoot,
  input wire logic applicationLockBit,
  input wire logic bootLockBit,
  input wire eisvs_pkg::eisvs_irq_t irqOut,
  input wire logic [16:0] vectorBase,
  input wire logic vectorTableSelect,
  input wire logic wakeRequest
);
  import eisvs_pkg::*;
  logic mcuWr;
  logic unlkWr;
  logic selWr;
  assign mcuWr = clkEn && regBus.wr && regBus.addr == ADDR_MCU_CONTROL;
  assign unlkWr = mcuWr && regBus.wdata[0];
  assign selWr = mcuWr && !regBus.wdata[0];
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  vec_base_a: assert property (!vectorTableSelect |-> vectorBase == 17'h0)
    else $error("vector base not zero with select clear");
  select_guard_a: assert property ($changed(vectorTableSelect) |-> $past(selWr) &&
    ($past(unlkWr, 2) || $past(unlkWr, 3) || $past(unlkWr, 4) || $past(unlkWr, 5)))
    else $error("select changed outside unlock window");
  unlock_block_a: assert property (unlkWr |=> !irqOut.valid)
    else $error("request shown after unlock write");
  unlock_hold_a: assert property (unlkWr ##1 !selWr [*3] |=> !irqOut.valid)
    else $error("request shown inside unlock window");
  lock_block_a: assert property (clkEn && ((vectorTableSelect && !execInBoot && applicationLockBit) ||
    (!vectorTableSelect && execInBoot && bootLockBit)) |=> !irqOut.valid)
    else $error("request shown while lock bit blocks");
  wake_quiet_a: assert property ($stable(pinChangeInputs) && $stable(extIrqPins) && &extIrqPins
    |-> !wakeRequest)
    else $error("wake raised with quiet pins");
  gie_block_a: assert property (clkEn && !globalIrqEnable |=> !irqOut.valid)
    else $error("request shown with i-flag clear");
  vec_range_a: assert property (irqOut.valid ? irqOut.vector <= 4'ha : irqOut.vector == VEC_NONE)
    else $error("vector code out of range");
  rd_idle_a: assert property (clkEn && !regBus.rd |=> regRdata == 8'h0)
    else $error("read data without read strobe");
endmodule
bind eisvs_top eisvs_top_properties chk (.clk(clk), .clkEn(clkEn), .reset_n(reset_n), .regBus(regBus),
  .regRdata(regRdata), .extIrqPins(extIrqPins), .pinChangeInputs(pinChangeInputs),
  .globalIrqEnable(globalIrqEnable), .execInBoot(execInBoot), .applicationLockBit(applicationLockBit),
  .bootLockBit(bootLockBit), .irqOut(irqOut), .vectorBase(vectorBase),
  .vectorTableSelect(vectorTableSelect), .wakeRequest(wakeRequest));

/* test/eisvs_cpu_model.sv */
/* eisvs_cpu_model: cpu side, retire pulses and prompt or slow acknowledge.
   assumes: irqIn registered by the design; acks only while ackEn high. */
`timescale 1ns/10ps
module eisvs_cpu_model (
  // clock, reset
  input wire logic clk,
  input wire logic reset_n,
  // interrupt side
  input wire eisvs_pkg::eisvs_irq_t irqIn,
  input wire logic ackEn,
  input wire logic slow,
  output logic irqAck = 1'b0,
  output logic instrRetire = 1'b0
);
  import eisvs_pkg::*;
  logic [1:0] cnt = 2'h0;
  logic [1:0] waitCnt = 2'h0;
  // four-cycle instructions; bench holds levels well past one retire
  always @(posedge clk) begin
    if (!reset_n) begin
      cnt <= 2'h0;
      waitCnt <= 2'h0;
      irqAck <= 1'b0;
      instrRetire <= 1'b0;
    end else begin
      cnt <= cnt + 2'h1;
      instrRetire <= cnt == 2'h2;
      waitCnt <= irqIn.valid ? waitCnt + 2'h1 : 2'h0;
      // no ack in the cycle after one: the flag is still clearing
      irqAck <= ackEn && irqIn.valid && !irqAck && (!slow || waitCnt == 2'h3);
    end
  end
endmodule

/* test/test_external_irq_sense_and_vector_select.sv */
/* test_external_irq_sense_and_vector_select: randomised self-checking bench.
   assumes: eisvs_top, eisvs_cpu_model and the bound checker compiled before. */
`timescale 1ns/10ps
module test_external_irq_sense_and_vector_select;
  import eisvs_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, gie = 1'b1, inBoot = 1'b0, appLock = 1'b0, bootLock = 1'b0;
  logic ackEn = 1'b0, slow = 1'b0, clkEn = 1'b1, irqAck, retire, vsel, wake;
  logic [7:0] pins = 8'hff, rdata;
  logic [23:0] pci = 24'h0;
  logic [16:0] bootStart = 17'h0, vbase;
  eisvs_bus_t bus = '0;
  eisvs_irq_t irq;
  int n_mismatch = 0, num_checks = 0, cycles = 0;
  logic [7:0] amap [11] = '{ADDR_MCU_CONTROL, ADDR_SENSE_LOW, ADDR_SENSE_HIGH, ADDR_EXT_MASK,
    ADDR_EXT_FLAG, ADDR_PC_CTRL, ADDR_PC_FLAG, ADDR_PC_MASK0, ADDR_PC_MASK1, ADDR_PC_MASK2, 8'h50};
  eisvs_top uut (.clk(clk), .clkEn(clkEn), .reset_n(reset_n), .regBus(bus), .regRdata(rdata),
    .extIrqPins(pins), .pinChangeInputs(pci), .globalIrqEnable(gie), .execInBoot(inBoot),
    .applicationLockBit(appLock), .bootLockBit(bootLock), .bootSectionStart(bootStart),
    .instrRetire(retire), .irqAck(irqAck), .irqOut(irq), .vectorBase(vbase),
    .vectorTableSelect(vsel), .wakeRequest(wake));
  eisvs_cpu_model cpu (.clk(clk), .reset_n(reset_n), .irqIn(irq), .ackEn(ackEn), .slow(slow),
    .irqAck(irqAck), .instrRetire(retire));
  task automatic test_done;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [16:0] seen, input logic [16:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [16:0] expIrq(input logic f, input int n);
    return f ? {12'h0, 1'b1, 4'(n)} : {12'h0, 1'b0, VEC_NONE};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus <= '0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) bus <= '{a, 8'h0, 1'b0, 1'b1};
    @(posedge clk) bus <= '0;
    @(negedge clk) check($sformatf("reg %h", a), 17'(rdata), 17'(exp));
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic rst;
    @(posedge clk) reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
  endtask
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      test_done;
    end
  end
  initial begin
    int n, m, g, b;
    logic e;
    logic [7:0] v;
    n = $urandom(32'h8f942a89);
    bootStart = 17'($urandom);
    rst;
    foreach (amap[i]) rdchk(amap[i], 8'h0);
    v = 8'($urandom);
    wr(ADDR_EXT_MASK, v);
    rdchk(ADDR_EXT_MASK, v);
    wr(ADDR_SENSE_LOW, ~v);
    rdchk(ADDR_SENSE_LOW, ~v);
    wr(ADDR_MCU_CONTROL, 8'hfe);
    rdchk(ADDR_MCU_CONTROL, MCU_PLAIN_MASK);
    wr(ADDR_MCU_CONTROL, 8'h00);
    repeat (16) begin
      n = $urandom_range(7, 0);
      m = $urandom_range(3, 0);
      e = $urandom_range(3, 0) != 0;
      wr(ADDR_EXT_MASK, 8'h0);
      wr(n < 4 ? ADDR_SENSE_LOW : ADDR_SENSE_HIGH, 8'(m << (2 * (n % 4))));
      wr(n < 4 ? ADDR_SENSE_HIGH : ADDR_SENSE_LOW, 8'h0);
      wr(ADDR_EXT_FLAG, 8'hff);
      @(posedge clk) gie <= e;
      wr(ADDR_EXT_MASK, 8'(1 << n));
      @(posedge clk) pins[n] <= 1'b0;
      settle;
      check("irq low", 17'(irq), expIrq(e && m != 3, n));
      @(posedge clk) pins[n] <= 1'b1;
      settle;
      check("irq high", 17'(irq), expIrq(e && m != 0, n));
      if ($urandom_range(1, 0)) wr(ADDR_EXT_FLAG, 8'(1 << n));
      else begin
        @(posedge clk) ackEn <= 1'b1;
        slow <= $urandom_range(1, 0);
        repeat (8) @(posedge clk);
        ackEn <= 1'b0;
      end
      settle;
      check("irq clear", 17'(irq), expIrq(1'b0, 0));
    end
    wr(ADDR_EXT_MASK, 8'h0);
    @(posedge clk) gie <= 1'b1;
    repeat (8) begin
      g = $urandom_range(2, 0);
      b = $urandom_range(7, 0);
      wr(ADDR_PC_CTRL, 8'(1 << g));
      wr(ADDR_PC_MASK0 + 8'(g), 8'(1 << b));
      wr(ADDR_PC_FLAG, 8'h07);
      @(posedge clk) pci[8 * g + (b + 1) % 8] <= ~pci[8 * g + (b + 1) % 8];
      @(negedge clk) check("pc masked wake", 17'(wake), 17'h0);
      settle;
      check("pc masked", 17'(irq), expIrq(1'b0, 0));
      @(posedge clk) pci[8 * g + b] <= ~pci[8 * g + b];
      @(negedge clk) check("pc wake", 17'(wake), 17'h1);
      settle;
      check("pc group", 17'(irq), expIrq(1'b1, 8 + g));
      wr(ADDR_PC_MASK0 + 8'(g), 8'h0);
      wr(ADDR_PC_FLAG, 8'h07);
    end
    wr(ADDR_SENSE_LOW, 8'h0);
    wr(ADDR_EXT_MASK, 8'h01);
    @(posedge clk) pins[0] <= 1'b0;
    wr(ADDR_MCU_CONTROL, 8'h01);
    wr(ADDR_MCU_CONTROL, 8'h02);
    rdchk(ADDR_MCU_CONTROL, 8'h02);
    check("base boot", vbase, bootStart);
    @(posedge clk) appLock <= 1'b1;
    settle;
    check("app locked", 17'(irq), expIrq(1'b0, 0));
    @(posedge clk) inBoot <= 1'b1;
    settle;
    check("boot run", 17'(irq), expIrq(1'b1, 0));
    check("wake level", 17'(wake), 17'h1);
    // clock enable low must hold the request although the level went away
    @(posedge clk) clkEn <= 1'b0;
    pins[0] <= 1'b1;
    settle;
    check("irq frozen", 17'(irq), expIrq(1'b1, 0));
    @(posedge clk) clkEn <= 1'b1;
    pins[0] <= 1'b0;
    settle;
    wr(ADDR_MCU_CONTROL, 8'h00);
    rdchk(ADDR_MCU_CONTROL, 8'h02);
    wr(ADDR_MCU_CONTROL, 8'h01);
    rdchk(ADDR_MCU_CONTROL, 8'h03);
    repeat (4) @(posedge clk);
    wr(ADDR_MCU_CONTROL, 8'h00);
    rdchk(ADDR_MCU_CONTROL, 8'h02);
    wr(ADDR_MCU_CONTROL, 8'h01);
    wr(ADDR_MCU_CONTROL, 8'h00);
    rdchk(ADDR_MCU_CONTROL, 8'h00);
    check("base flash", vbase, 17'h0);
    @(posedge clk) bootLock <= 1'b1;
    settle;
    check("boot locked", 17'(irq), expIrq(1'b0, 0));
    wr(ADDR_MCU_CONTROL, 8'h01);
    wr(ADDR_MCU_CONTROL, 8'h02);
    rst;
    @(negedge clk) check("select reset", 17'(vsel), 17'h0);
    rdchk(ADDR_EXT_MASK, 8'h0);
    test_done;
  end
endmodule
